// >>> rtl/ref_qualify_defs.svh
`ifndef REF_QUALIFY_DEFS_SVH
`define REF_QUALIFY_DEFS_SVH
// Register offsets
`define OFS_INHIBIT_LOW 8'h1a
`define OFS_INHIBIT_HIGH 8'h1b
`define OFS_QUALIFY_TIMING 8'h1c
`define OFS_LOOP1_CTRL0 8'h1d
`define OFS_EVENT_STATUS 8'h20
`define OFS_EVENT_MASK 8'h21
// Reset values
`define RST_INHIBIT 8'hff
`define RST_QUALIFY_TIMING 8'h1a
`define RST_EVENT_MASK 8'h00
`define RST_SLOPE_STRATUM 4'h7
// Field positions in the loop control register
`define POS_HITLESS 0
`define POS_BW_LO 1
`define POS_BW_HI 3
`define POS_STRATUM_LO 6
`define POS_STRATUM_HI 7
// Bandwidth codes
`define BW_FAST_LOCK 3'h6
`define BW_890HZ 3'h5
`define BW_28HZ 3'h4
`define BW_STRATUM 3'h7
// Disqualify delay base tick: 0.5 ms at 125 MHz
`define TICK_NS 500000
`define CLK_NS 8
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`define MIN_DELAY_TICKS 24'h000001
`endif

// >>> rtl/ref_qualify_pkg.sv
package ref_qualify_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} host_req_t;
	typedef enum logic [1:0] {
		BW_SRC_TABLE = 2'b00,
		BW_SRC_STRATUM = 2'b01,
		BW_SRC_CAPPED = 2'b10
	} bw_src_t;
	typedef enum logic [1:0] {
		REF_RATE_OTHER = 2'b00,
		REF_RATE_2K = 2'b01,
		REF_RATE_8K = 2'b10
	} ref_rate_t;
endpackage : ref_qualify_pkg

// >>> rtl/ref_qualify_and_loop_ctrl.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "ref_qualify_defs.svh"
module ref_qualify_and_loop_ctrl
	import ref_qualify_pkg::*;
(
	input wire logic mclk, // 125 MHz clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic [7:0] hostAddr, // Register address
	input wire logic [7:0] hostWdata, // Write data
	input wire logic hostWr, // Write strobe
	input wire logic hostRd, // Read strobe
	output logic [7:0] hostRdata, // Read data, cycle after strobe
	input wire logic [7:0] coarseFreqFail, // Per-reference monitor fail, async
	input wire logic [7:0] singleCycleFail, // Per-reference monitor fail, async
	input wire logic [1:0] lockedRefRate, // Rate class of locked reference
	input wire logic refSwitch, // Reference switch event, same clock
	input wire logic hitlessEnablePin, // Strap pin, async
	input wire logic slaveEnablePin, // Strap pin, async
	output logic [7:0] refQualified, // Per-reference qualified state
	output logic [7:0] monitorInhibit, // Single-cycle inhibit, refs 7..0
	output logic [7:0] coarseInhibit, // Coarse-frequency inhibit, refs 7..0
	output logic buildOutPhase, // Absorb phase offset on switch
	output logic realignPhase, // Realign to new reference on switch
	output logic [2:0] effBwCode, // Effective bandwidth table code
	output logic [1:0] stratumBw, // Stratum bandwidth code in use
	output bw_src_t bwSource, // Where effective bandwidth comes from
	output logic irq // Level interrupt
);
	// Host request bundle
	host_req_t req; // Register port request

	// Software-visible registers
	logic [7:0] inhibitLow_reg; // Inhibit pairs, references 0..3
	logic [7:0] inhibitHigh_reg; // Inhibit pairs, references 4..7
	logic [7:0] qualTime_reg; // Disqualify code and requalify multiple
	logic [7:0] loopCtrl_reg; // Loop control, hitless and bandwidth
	logic [7:0] evStatus_reg; // Sticky disqualify events
	logic [7:0] evMask_reg; // Interrupt enables for the events

	// Strap capture
	logic [2:0] strapHs_reg; // Hitless pin, three flops
	logic [2:0] strapSlave_reg; // Slave pin, three flops
	logic [1:0] strapAge_reg; // Edges since reset release, saturating
	logic strapDone_reg; // Loop control defaults taken

	// Monitor synchronisers
	logic [7:0] cfS1_reg; // Coarse-frequency, first flop
	logic [7:0] cfS2_reg; // Coarse-frequency, second flop
	logic [7:0] cfS3_reg; // Coarse-frequency, third flop
	logic [7:0] scS1_reg; // Single-cycle, first flop
	logic [7:0] scS2_reg; // Single-cycle, second flop
	logic [7:0] scS3_reg; // Single-cycle, third flop
	logic [7:0] cfAgreed_reg; // Coarse-frequency fail, filtered
	logic [7:0] scAgreed_reg; // Single-cycle fail, filtered

	// Timer state
	logic [15:0] tickCnt_reg; // Cycle count within one tick
	logic tick_reg; // One-cycle pulse every 0.5 ms
	logic [7:0] qualified_reg; // Per-reference qualified state
	logic [7:0] disqualEv; // Reference drops out this cycle
	logic [7:0] requalEv; // Reference returns this cycle
	logic [23:0] disqTicks; // Disqualify delay in ticks
	logic [23:0] reqTicks; // Requalify time in ticks

	// Combinational helpers
	logic [7:0] rdataNext; // Read mux result
	logic [15:0] inhibitAll; // Both inhibit registers, reference order
	logic [7:0] monitorNext; // Single-cycle inhibit per reference
	logic [7:0] coarseNext; // Coarse-frequency inhibit per reference
	logic hitlessDefault; // Strap-derived hitless bit
	logic [2:0] bwDefault; // Strap-derived bandwidth code

	assign req = '{addr: hostAddr, wdata: hostWdata, wr: hostWr, rd: hostRd};

	// Address decode
	wire selLow = req.addr == `OFS_INHIBIT_LOW;
	wire selHigh = req.addr == `OFS_INHIBIT_HIGH;
	wire selQual = req.addr == `OFS_QUALIFY_TIMING;
	wire selLoop = req.addr == `OFS_LOOP1_CTRL0;
	wire selStat = req.addr == `OFS_EVENT_STATUS;
	wire selMask = req.addr == `OFS_EVENT_MASK;

	// Read mux; unmapped addresses read zero
	always_comb begin
		if (selLow) rdataNext = inhibitLow_reg;
		else if (selHigh) rdataNext = inhibitHigh_reg;
		else if (selQual) rdataNext = qualTime_reg;
		else if (selLoop) rdataNext = loopCtrl_reg;
		else if (selStat) rdataNext = evStatus_reg;
		else if (selMask) rdataNext = evMask_reg;
		else rdataNext = 8'h00;
	end

	// Read data stands one cycle, zero otherwise
	always_ff @(posedge mclk) begin
		if (srst) begin
			hostRdata <= 8'h00;
		end else if (req.rd) begin
			hostRdata <= rdataNext;
		end else begin
			hostRdata <= 8'h00;
		end
	end

	// Strap pins pass three flops; second and third must agree
	always_ff @(posedge mclk) begin
		if (srst) begin
			strapHs_reg <= 3'h0;
			strapSlave_reg <= 3'h0;
		end else begin
			strapHs_reg <= {strapHs_reg[1:0], hitlessEnablePin};
			strapSlave_reg <= {strapSlave_reg[1:0], slaveEnablePin};
		end
	end

	// Chain holds real pin samples only three edges after release;
	// before that the reset zeros would look like a settled strap.
	always_ff @(posedge mclk) begin
		if (srst) begin
			strapAge_reg <= 2'h0;
		end else if (strapAge_reg != 2'h3) begin
			strapAge_reg <= strapAge_reg + 2'h1;
		end
	end
	wire strapFull = strapAge_reg == 2'h3;
	wire strapStable = (strapHs_reg[1] == strapHs_reg[2])
		&& (strapSlave_reg[1] == strapSlave_reg[2]);
	assign hitlessDefault = !(strapHs_reg[2] && !strapSlave_reg[2]);
	assign bwDefault = strapSlave_reg[2] ? `BW_890HZ : `BW_FAST_LOCK;

	// Inhibit masks and qualify timing
	always_ff @(posedge mclk) begin
		if (srst) begin
			inhibitLow_reg <= `RST_INHIBIT;
			inhibitHigh_reg <= `RST_INHIBIT;
			qualTime_reg <= `RST_QUALIFY_TIMING;
		end else if (req.wr) begin
			if (selLow) inhibitLow_reg <= req.wdata;
			if (selHigh) inhibitHigh_reg <= req.wdata;
			if (selQual) qualTime_reg <= {2'b00, req.wdata[5:0]};
		end
	end

	// Loop control: defaults captured from straps after reset release.
	// Capture waits for the straps to settle, then is done once.
	always_ff @(posedge mclk) begin
		if (srst) begin
			loopCtrl_reg <= 8'h00;
			strapDone_reg <= 1'b0;
		end else if (!strapDone_reg) begin
			// Slope field unlimited, stratum field at its default
			if (strapFull && strapStable) begin
				loopCtrl_reg <= {`RST_SLOPE_STRATUM, bwDefault, hitlessDefault};
				strapDone_reg <= 1'b1;
			end
		end else if (req.wr && selLoop) begin
			loopCtrl_reg <= req.wdata;
		end
	end

	// Base tick of 0.5 ms
	always_ff @(posedge mclk) begin
		if (srst || tickCnt_reg == 16'(`TICK_CYCLES - 1)) tickCnt_reg <= 16'h0000;
		else tickCnt_reg <= tickCnt_reg + 16'h0001;
	end

	// Tick pulse registered to keep the compare off the timer path
	always_ff @(posedge mclk) begin
		if (srst) tick_reg <= 1'b0;
		else tick_reg <= tickCnt_reg == 16'(`TICK_CYCLES - 1);
	end

	// Disqualify delay in 0.5 ms ticks
	always_comb begin
		// Code zero uses the single tick, the shortest the timer can do
		case (qualTime_reg[3:0])
		4'h0: disqTicks = `MIN_DELAY_TICKS;
		4'h1: disqTicks = 24'd1;
		4'h2: disqTicks = 24'd2;
		4'h3: disqTicks = 24'd10;
		4'h4: disqTicks = 24'd20;
		4'h5: disqTicks = 24'd100;
		4'h6: disqTicks = 24'd200;
		4'h7: disqTicks = 24'd1000;
		4'h8: disqTicks = 24'd2000;
		4'h9: disqTicks = 24'd4000;
		4'ha: disqTicks = 24'd5000;
		4'hb: disqTicks = 24'd8000;
		4'hc: disqTicks = 24'd16000;
		4'hd: disqTicks = 24'd32000;
		4'he: disqTicks = 24'd64000;
		default: disqTicks = 24'd128000;
		endcase
	end

	// Requalify multiple
	always_comb begin
		// Shifts keep the multiple exact; 64 s times 32 still fits
		case (qualTime_reg[5:4])
		2'h0: reqTicks = disqTicks << 1;
		2'h1: reqTicks = disqTicks << 2;
		2'h2: reqTicks = disqTicks << 4;
		default: reqTicks = disqTicks << 5;
		endcase
	end

	assign inhibitAll = {inhibitHigh_reg, inhibitLow_reg};

	// Monitor inputs pass three flops each
	// A level seen by one flop only is not taken as a failure
	always_ff @(posedge mclk) begin
		if (srst) begin
			cfS1_reg <= 8'h00;
			cfS2_reg <= 8'h00;
			cfS3_reg <= 8'h00;
			scS1_reg <= 8'h00;
			scS2_reg <= 8'h00;
			scS3_reg <= 8'h00;
		end else begin
			cfS1_reg <= coarseFreqFail;
			cfS2_reg <= cfS1_reg;
			cfS3_reg <= cfS2_reg;
			scS1_reg <= singleCycleFail;
			scS2_reg <= scS1_reg;
			scS3_reg <= scS2_reg;
		end
	end

	// Per-reference integrating timer
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gRef
			logic [23:0] failCnt_reg, cleanCnt_reg;
			logic cfOk, scOk;
			assign cfOk = cfS2_reg[g] == cfS3_reg[g];
			assign scOk = scS2_reg[g] == scS3_reg[g];
			always_ff @(posedge mclk) begin
				if (srst) begin
					cfAgreed_reg[g] <= 1'b0;
					scAgreed_reg[g] <= 1'b0;
				end else begin
					if (cfOk) cfAgreed_reg[g] <= cfS3_reg[g];
					if (scOk) scAgreed_reg[g] <= scS3_reg[g];
				end
			end
			// Low bit gates single-cycle, high bit coarse-frequency
			wire failing = (scAgreed_reg[g] && !inhibitAll[2*g])
				|| (cfAgreed_reg[g] && !inhibitAll[2*g+1]);
			// Split each pair for the registered outputs
			assign monitorNext[g] = inhibitAll[2*g];
			assign coarseNext[g] = inhibitAll[2*g+1];
			// Terminal count checked on the tick that would reach it
			assign disqualEv[g] = qualified_reg[g] && failing && tick_reg
				&& failCnt_reg + 24'd1 >= disqTicks;
			assign requalEv[g] = !qualified_reg[g] && !failing && tick_reg
				&& cleanCnt_reg + 24'd1 >= reqTicks;
			// A change of failing state restarts the other count
			always_ff @(posedge mclk) begin
				if (srst) begin
					failCnt_reg <= 24'h000000;
					cleanCnt_reg <= 24'h000000;
					qualified_reg[g] <= 1'b0;
				end else if (disqualEv[g]) begin
					qualified_reg[g] <= 1'b0;
					failCnt_reg <= 24'h000000;
					cleanCnt_reg <= 24'h000000;
				end else if (requalEv[g]) begin
					qualified_reg[g] <= 1'b1;
					failCnt_reg <= 24'h000000;
					cleanCnt_reg <= 24'h000000;
				end else if (failing) begin
					cleanCnt_reg <= 24'h000000;
					if (tick_reg) failCnt_reg <= failCnt_reg + 24'd1;
				end else begin
					failCnt_reg <= 24'h000000;
					if (tick_reg) cleanCnt_reg <= cleanCnt_reg + 24'd1;
				end
			end
		end
	endgenerate

	// Write-one-to-clear bits, then new events; set wins over clear
	wire [7:0] statusClear = (req.wr && selStat) ? req.wdata : 8'h00;
	wire [7:0] statusNext = (evStatus_reg & ~statusClear) | disqualEv;

	// Event status: disqualify per reference
	always_ff @(posedge mclk) begin
		if (srst) evStatus_reg <= 8'h00;
		else evStatus_reg <= statusNext;
	end

	// Interrupt enables
	always_ff @(posedge mclk) begin
		if (srst) evMask_reg <= `RST_EVENT_MASK;
		else if (req.wr && selMask) evMask_reg <= req.wdata;
	end

	// Bandwidth resolution with rate caps
	wire [2:0] bwField = loopCtrl_reg[`POS_BW_HI:`POS_BW_LO];
	wire capTo14 = (bwField == `BW_28HZ || bwField == `BW_890HZ)
		&& lockedRefRate == REF_RATE_2K;
	wire capTo56 = bwField == `BW_890HZ && lockedRefRate == REF_RATE_8K;
	logic [2:0] effBwNext;
	bw_src_t srcNext;
	always_comb begin
		effBwNext = bwField;
		srcNext = BW_SRC_TABLE;
		if (bwField == `BW_STRATUM) srcNext = BW_SRC_STRATUM;
		else if (capTo14) begin
			effBwNext = 3'h3;
			srcNext = BW_SRC_CAPPED;
		end else if (capTo56) srcNext = BW_SRC_CAPPED; // 56 Hz has no table code
	end

	// Inhibit outputs, registered so every output leaves a flop
	always_ff @(posedge mclk) begin
		if (srst) begin
			monitorInhibit <= `RST_INHIBIT;
			coarseInhibit <= `RST_INHIBIT;
		end else begin
			monitorInhibit <= monitorNext;
			coarseInhibit <= coarseNext;
		end
	end

	// Qualified state and switch pulses; pulses last as long as refSwitch, one cycle late
	always_ff @(posedge mclk) begin
		if (srst) begin
			refQualified <= 8'h00;
			buildOutPhase <= 1'b0;
			realignPhase <= 1'b0;
		end else begin
			refQualified <= qualified_reg;
			buildOutPhase <= refSwitch && !loopCtrl_reg[`POS_HITLESS];
			realignPhase <= refSwitch && loopCtrl_reg[`POS_HITLESS];
		end
	end

	// Bandwidth outputs follow the control register one cycle late
	always_ff @(posedge mclk) begin
		if (srst) begin
			effBwCode <= 3'h0;
			stratumBw <= 2'h1;
			bwSource <= BW_SRC_TABLE;
		end else begin
			effBwCode <= effBwNext;
			// Reserved code 11 held at the default
			stratumBw <= (loopCtrl_reg[`POS_STRATUM_HI:`POS_STRATUM_LO] == 2'h3) ? 2'h1
				: loopCtrl_reg[`POS_STRATUM_HI:`POS_STRATUM_LO];
			bwSource <= srcNext;
		end
	end

	// Level interrupt from any enabled sticky event
	always_ff @(posedge mclk) begin
		if (srst) irq <= 1'b0;
		else irq <= |(evStatus_reg & evMask_reg);
	end
endmodule : ref_qualify_and_loop_ctrl

// >>> verification/ref_qualify_and_loop_ctrl_assertions.sv
`timescale 1ns/1ps
module ref_qualify_and_loop_ctrl_assertions
	import ref_qualify_pkg::*;
(
	input wire logic mclk, // Clock
	input wire logic srst, // Sync reset
	input wire logic [7:0] hostAddr, // Address
	input wire logic [7:0] hostWdata, // Write data
	input wire logic hostWr, // Write strobe
	input wire logic hostRd, // Read strobe
	input wire logic [7:0] hostRdata, // Read data
	input wire logic [1:0] lockedRefRate, // Locked rate class
	input wire logic refSwitch, // Switch event
	input wire logic hitlessEnablePin, // Strap
	input wire logic slaveEnablePin, // Strap
	input wire logic [7:0] refQualified, // Qualified state
	input wire logic [7:0] monitorInhibit, // Single-cycle inhibit
	input wire logic [7:0] coarseInhibit, // Coarse inhibit
	input wire logic buildOutPhase, // Build-out pulse
	input wire logic realignPhase, // Realign pulse
	input wire logic [2:0] effBwCode, // Effective code
	input wire logic [1:0] stratumBw, // Stratum code
	input wire bw_src_t bwSource // Bandwidth source
);
	logic [15:0] pairs;
	logic [7:0] ctrlReg;
	logic [16:0] sinceRst;
	wire [2:0] bw = ctrlReg[3:1];
	// Inhibit outputs regrouped in register bit order
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pairs[2*i] = monitorInhibit[i];
			pairs[2*i+1] = coarseInhibit[i];
		end
	end
	// Shadow of loop control; straps assumed steady across reset
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrlReg <= {4'h7, slaveEnablePin ? 3'h5 : 3'h6, ~(hitlessEnablePin & ~slaveEnablePin)};
		end else if (hostWr && hostAddr == 8'h1d) begin
			ctrlReg <= hostWdata;
		end
	end
	// Saturating age since reset release
	always_ff @(posedge mclk) begin
		if (srst) begin
			sinceRst <= 17'h00000;
		end else if (sinceRst != 17'h1ffff) begin
			sinceRst <= sinceRst + 17'h00001;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// Eight quiet cycles cover the strap capture delay too
	sequence s_settled;
		($stable(ctrlReg) && $stable(lockedRefRate)) [*8];
	endsequence
	a_low_pair_map: assert property (
		hostWr && hostAddr == 8'h1a |=> ##1 pairs[7:0] == $past(hostWdata, 2))
		else $error("low inhibit fields misplaced");
	a_high_pair_map: assert property (
		hostWr && hostAddr == 8'h1b |=> ##1 pairs[15:8] == $past(hostWdata, 2))
		else $error("high inhibit fields misplaced");
	a_inhibit_reset_ones: assert property ($fell(srst) |-> pairs == 16'hffff)
		else $error("inhibits not all ones after reset");
	a_hitless_pulse_select: assert property (
		refSwitch |=> {buildOutPhase, realignPhase} == {~$past(ctrlReg[0]), $past(ctrlReg[0])})
		else $error("wrong switch action");
	a_bw_table_code: assert property (
		s_settled ##0 (bw < 3'h4 || bw == 3'h6) |-> effBwCode == bw && bwSource == BW_SRC_TABLE)
		else $error("table bandwidth wrong");
	a_bw_rate_cap: assert property (
		s_settled ##0 ((bw == 3'h4 && lockedRefRate == REF_RATE_2K) || (bw == 3'h5 &&
		(lockedRefRate == REF_RATE_2K || lockedRefRate == REF_RATE_8K))) |-> bwSource == BW_SRC_CAPPED)
		else $error("bandwidth cap missing");
	a_bw_stratum_field: assert property (
		s_settled ##0 bw == 3'h7 |-> bwSource == BW_SRC_STRATUM &&
		stratumBw == (ctrlReg[7:6] == 2'b11 ? 2'b01 : ctrlReg[7:6]))
		else $error("stratum bandwidth wrong");
	a_rdata_idle_zero: assert property (!hostRd |=> hostRdata == 8'h00)
		else $error("read data outside its cycle");
	a_requal_min_hold: assert property (sinceRst < 17'h1e848 |-> refQualified == 8'h00)
		else $error("reference qualified too early");
endmodule : ref_qualify_and_loop_ctrl_assertions
bind ref_qualify_and_loop_ctrl ref_qualify_and_loop_ctrl_assertions chk_u (.*);

// >>> verification/tb_ref_qualify_and_loop_ctrl.sv
`timescale 1ns/1ps
module tb_ref_qualify_and_loop_ctrl import ref_qualify_pkg::*;;
	logic mclk = 1'b0, srst = 1'b1, hostWr = 1'b0, hostRd = 1'b0, refSwitch = 1'b0;
	logic hitlessEnablePin = 1'b1, slaveEnablePin = 1'b0, buildOutPhase, realignPhase, irq;
	logic [7:0] hostAddr = 8'h00, hostWdata = 8'h00, coarseFreqFail = 8'h00;
	logic [7:0] singleCycleFail = 8'h00, hostRdata, refQualified, monitorInhibit, coarseInhibit;
	logic [1:0] lockedRefRate = 2'b00, stratumBw;
	logic [2:0] effBwCode;
	bw_src_t bwSource;
	int miscompares = 0, cmp_count = 0;
	always #4 mclk = ~mclk;
	ref_qualify_and_loop_ctrl dut_u (.*);
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		hostWr <= 1'b1;
		hostAddr <= a;
		hostWdata <= d;
		@(posedge mclk);
		hostWr <= 1'b0;
	endtask : wr
	// Read data is only valid in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		hostRd <= 1'b1;
		hostAddr <= a;
		@(posedge mclk);
		hostRd <= 1'b0;
		@(negedge mclk);
		chk(hostRdata, exp);
	endtask : rd
	// Straps change as reset asserts and settle before its release, so the capture sees them
	task rst(input logic h, input logic s);
		@(posedge mclk);
		hitlessEnablePin <= h;
		slaveEnablePin <= s;
		srst <= 1'b1;
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask : rst
	task t_defaults;
		rst(1'b1, 1'b0);
		rd(8'h1a, 8'hff);
		rd(8'h1b, 8'hff);
		rd(8'h1c, 8'h1a);
		rd(8'h1d, 8'h7c);
		rd(8'h21, 8'h00);
		rd(8'h30, 8'h00);
		rst(1'b1, 1'b1);
		rd(8'h1d, 8'h7b);
		rst(1'b0, 1'b0);
		rd(8'h1d, 8'h7d);
	endtask : t_defaults
	task t_masks;
		wr(8'h1a, 8'h1b);
		wr(8'h1b, 8'hc6);
		coarseFreqFail <= 8'h5a;
		singleCycleFail <= 8'ha5;
		@(posedge mclk);
		@(negedge mclk);
		chk(monitorInhibit, 8'ha5);
		chk(coarseInhibit, 8'h93);
		rd(8'h1b, 8'hc6);
		chk(refQualified, 8'h00);
	endtask : t_masks
	task t_timing;
		wr(8'h1c, 8'hff);
		rd(8'h1c, 8'h3f);
		wr(8'h1c, 8'h00);
		rd(8'h1c, 8'h00);
	endtask : t_timing
	// Every code at every rate class, loop bits 5:4 kept unlimited
	task t_bw;
		logic [1:0] src;
		for (int c = 0; c < 8; c++) begin
			for (int r = 0; r < 3; r++) begin
				wr(8'h1d, {4'hb, c[2:0], 1'b1});
				lockedRefRate <= r[1:0];
				repeat (4) @(posedge mclk);
				@(negedge mclk);
				src = (c == 7) ? 2'b01 : ((c == 4 && r == 1) || (c == 5 && r > 0)) ? 2'b10 : 2'b00;
				chk({6'h00, bwSource}, {6'h00, src});
				if (src == 2'b00) chk({5'h00, effBwCode}, {5'h00, c[2:0]});
				if (src == 2'b10) chk({5'h00, effBwCode}, (r == 2) ? 8'h05 : 8'h03);
				if (c == 7) chk({6'h00, stratumBw}, 8'h02);
			end
		end
		wr(8'h1d, 8'hff);
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		chk({6'h00, stratumBw}, 8'h01);
	endtask : t_bw
	task t_switch;
		for (int b = 0; b < 2; b++) begin
			wr(8'h1d, {7'h3e, b[0]});
			@(posedge mclk);
			refSwitch <= 1'b1;
			@(posedge mclk);
			refSwitch <= 1'b0;
			@(negedge mclk);
			chk({6'h00, buildOutPhase, realignPhase}, (b == 1) ? 8'h01 : 8'h02);
			@(negedge mclk);
			chk({6'h00, buildOutPhase, realignPhase}, 8'h00);
		end
	endtask : t_switch
	// No reference can requalify this soon, so the status stays clear
	task t_irq;
		wr(8'h21, 8'hff);
		rd(8'h21, 8'hff);
		wr(8'h20, 8'hff);
		rd(8'h20, 8'h00);
		chk({7'h00, irq}, 8'h00);
	endtask : t_irq
	task results;
		$display("compares %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results
	initial begin
		t_defaults;
		t_masks;
		t_timing;
		t_bw;
		t_switch;
		t_irq;
		results;
	end
	// Watchdog against a stalled sequence
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		results;
	end
endmodule : tb_ref_qualify_and_loop_ctrl
